// ### hw/uart_regmap.sv
// register bank select, storage and internal loopback routing
`timescale 1ns/1ns
`default_nettype none
module uart_regmap
   import uart_regmap_pkg::*;
#(
   parameter logic [7:0] REVISION_CODE = 8'h01,  // arbitrary value
   parameter logic [7:0] IDENT_CODE    = 8'h5A   // arbitrary value
)(
   input  wire logic       mclk_in,
   input  wire logic       rst_in,
   input  wire logic       ce_in,
   input  wire logic [2:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   input  wire logic [7:0] rx_holding_in,
   input  wire logic [7:0] interrupt_status_in,
   input  wire logic [7:0] line_status_in,
   input  wire logic [7:0] fifo_level_count_in,
   input  wire logic [3:0] modem_delta_in,
   output logic            tx_holding_wr_out,
   output logic            fifo_control_wr_out,
   output logic            rx_holding_rd_out,
   output logic            line_status_rd_out,
   output logic            modem_status_rd_out,
   output logic            fifo_trigger_wr_out,
   output logic            enhanced_mode_wr_out,
   output logic [7:0]      wr_data_out,
   input  wire logic       tx_shift_in,
   input  wire logic       rx_pin_in,
   output logic            rx_shift_out,
   output logic            tx_pin_out,
   input  wire logic       cts_n_in,
   input  wire logic       dsr_n_in,
   input  wire logic       cd_n_in,
   input  wire logic       ri_n_in,
   output logic            rts_n_out,
   output logic            dtr_n_out,
   output logic [3:0]      modem_lines_out,
   output logic            loopback_out,
   output logic            infrared_en_out,
   output logic            infrared_fast_out,
   output logic [7:0]      divisor_low_out,
   output logic [7:0]      divisor_high_out,
   output logic [7:0]      divisor_frac_out,
   output logic [7:0]      interrupt_enable_out,
   output logic [7:0]      line_control_out,
   output logic [7:0]      feature_control_out,
   output logic [7:0]      enhanced_function_out
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   // rdata sits last so it is the low byte of the packed state
   typedef struct packed {
      logic [7:0] div_lo;
      logic [7:0] div_hi;
      logic [7:0] div_frac;
      logic [7:0] int_en;
      logic [7:0] line_ctl;
      logic [7:0] modem_ctl;
      logic [7:0] stat_ctl;
      logic [7:0] scratch;
      logic [7:0] feat_ctl;
      logic [7:0] enh_fn;
      logic [7:0] resume_1;
      logic [7:0] resume_2;
      logic [7:0] pause_1;
      logic [7:0] pause_2;
      logic [7:0] rdata;
   } state_t;

   state_t s_q;
   state_t s_d;

   // ----------------------------------------
   // bank decode
   // ----------------------------------------
   logic key_sel;
   logic div_sel;
   logic enh_en;
   logic id_sel;
   logic loop;
   logic [7:0] modem_stat;

   assign key_sel = (s_q.line_ctl == ENHANCED_KEY);
   assign div_sel = s_q.line_ctl[BANK_BIT] && !key_sel;
   assign enh_en  = s_q.enh_fn[ENH_EN_BIT];
   assign id_sel  = div_sel && (s_q.div_lo == 8'h00) && (s_q.div_hi == 8'h00);
   assign loop    = s_q.modem_ctl[LOOPBACK_BIT];

   assign modem_lines_out = loop ? 4'h0 : {~cd_n_in, ~ri_n_in, ~dsr_n_in, ~cts_n_in};
   assign modem_stat = {modem_lines_out, loop ? 4'h0 : modem_delta_in};

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb
   begin
      s_d = s_q;
      tx_holding_wr_out    = 1'b0;
      fifo_control_wr_out  = 1'b0;
      rx_holding_rd_out    = 1'b0;
      line_status_rd_out   = 1'b0;
      modem_status_rd_out  = 1'b0;
      fifo_trigger_wr_out  = 1'b0;
      enhanced_mode_wr_out = 1'b0;
      if (ce_in && wr_in)
      begin
         unique case (addr_in)
            ADDR_0:
               if (key_sel) fifo_trigger_wr_out = 1'b1;
               else if (div_sel) s_d.div_lo = wdata_in;
               else tx_holding_wr_out = 1'b1;
            ADDR_1:
               if (key_sel) s_d.feat_ctl = wdata_in;
               else if (div_sel) s_d.div_hi = wdata_in;
               else s_d.int_en = wdata_in;
            ADDR_2:
               if (key_sel) s_d.enh_fn = wdata_in;
               else if (div_sel && enh_en) s_d.div_frac = wdata_in;
               // fifo control, also with divisor bank while enhanced off
               else fifo_control_wr_out = 1'b1;
            ADDR_3: s_d.line_ctl = wdata_in;
            ADDR_4:
               if (key_sel) s_d.resume_1 = wdata_in;
               else s_d.modem_ctl = wdata_in;
            ADDR_5: if (key_sel) s_d.resume_2 = wdata_in;
            ADDR_6:
               if (key_sel) s_d.pause_1 = wdata_in;
               else if (enh_en) s_d.stat_ctl = wdata_in;
            ADDR_7:
               if (key_sel) s_d.pause_2 = wdata_in;
               else if (s_q.feat_ctl[WINDOW_BIT]) enhanced_mode_wr_out = 1'b1;
               else s_d.scratch = wdata_in;
         endcase
      end
      if (ce_in && rd_in)
      begin
         unique case (addr_in)
            ADDR_0:
               if (key_sel) s_d.rdata = fifo_level_count_in;
               else if (id_sel) s_d.rdata = REVISION_CODE;
               else if (div_sel) s_d.rdata = s_q.div_lo;
               else
               begin
                  s_d.rdata = rx_holding_in;
                  rx_holding_rd_out = 1'b1;
               end
            ADDR_1:
               if (key_sel) s_d.rdata = s_q.feat_ctl;
               else if (id_sel) s_d.rdata = IDENT_CODE;
               else if (div_sel) s_d.rdata = s_q.div_hi;
               else s_d.rdata = s_q.int_en;
            ADDR_2:
               if (key_sel) s_d.rdata = s_q.enh_fn;
               else if (div_sel && enh_en) s_d.rdata = s_q.div_frac;
               else s_d.rdata = interrupt_status_in;
            ADDR_3: s_d.rdata = s_q.line_ctl;
            ADDR_4: s_d.rdata = key_sel ? s_q.resume_1 : s_q.modem_ctl;
            ADDR_5:
               if (key_sel) s_d.rdata = s_q.resume_2;
               else
               begin
                  s_d.rdata = line_status_in;
                  line_status_rd_out = 1'b1;
               end
            ADDR_6:
               if (key_sel) s_d.rdata = s_q.pause_1;
               else
               begin
                  s_d.rdata = modem_stat;
                  modem_status_rd_out = 1'b1;
               end
            ADDR_7:
               if (key_sel) s_d.rdata = s_q.pause_2;
               else if (s_q.feat_ctl[WINDOW_BIT]) s_d.rdata = fifo_level_count_in;
               else s_d.rdata = s_q.scratch;
         endcase
      end
   end

   always_ff @(posedge mclk_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         s_q          <= '0;
         s_q.line_ctl <= LINE_CTL_RESET;
      end
      else if (ce_in)
         s_q <= s_d;
   end

   // ----------------------------------------
   // outputs and loopback routing
   // ----------------------------------------
   assign rdata_out   = s_q.rdata;
   assign wr_data_out = wdata_in;
   assign rx_shift_out = loop ? tx_shift_in : rx_pin_in;
   assign tx_pin_out   = loop ? 1'b1 : tx_shift_in;
   assign rts_n_out    = loop ? 1'b1 : ~s_q.modem_ctl[RTS_BIT];
   assign dtr_n_out    = loop ? 1'b1 : ~s_q.modem_ctl[DTR_BIT];
   assign loopback_out = loop;
   assign infrared_en_out   = s_q.modem_ctl[INFRARED_BIT];
   assign infrared_fast_out = s_q.modem_ctl[INFRARED_BIT] && enh_en && s_q.stat_ctl[FAST_IR_BIT];
   assign divisor_low_out       = s_q.div_lo;
   assign divisor_high_out      = s_q.div_hi;
   assign divisor_frac_out      = s_q.div_frac;
   assign interrupt_enable_out  = s_q.int_en;
   assign line_control_out      = s_q.line_ctl;
   assign feature_control_out   = s_q.feat_ctl;
   assign enhanced_function_out = s_q.enh_fn;

   // ----------------------------------------
   // bank checks
   // ----------------------------------------
   // writes are checked one edge later, when the register shows them
   chk_div_low_write: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == ADDR_0 && div_sel |=> divisor_low_out == $past(wdata_in))
      else $error("divisor low write lost");
   chk_rev_read: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && rd_in && addr_in == ADDR_0 && id_sel |=> rdata_out == REVISION_CODE)
      else $error("revision code not returned");
   chk_frac_gate: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == ADDR_2 && !(div_sel && enh_en) |=> $stable(divisor_frac_out))
      else $error("fraction written while gated");
   chk_thr_strobe: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == ADDR_0 && !key_sel && !div_sel |-> tx_holding_wr_out)
      else $error("tx holding strobe missing");
   chk_ier_write: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == ADDR_1 && !s_q.line_ctl[BANK_BIT]
      |=> interrupt_enable_out == $past(wdata_in))
      else $error("interrupt enable write lost");
   chk_fcr_strobe: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == ADDR_2 && !key_sel && !(div_sel && enh_en)
      |-> fifo_control_wr_out)
      else $error("fifo control strobe missing");
   chk_mcr_write: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == ADDR_4 && !key_sel |=> s_q.modem_ctl == $past(wdata_in))
      else $error("modem control write lost");
   chk_msw_gate: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == ADDR_6 && (key_sel || !enh_en) |=> $stable(s_q.stat_ctl))
      else $error("status write control not gated");
   chk_scratch_write: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == ADDR_7 && !key_sel && !s_q.feat_ctl[WINDOW_BIT]
      |=> s_q.scratch == $past(wdata_in))
      else $error("scratch pad write lost");
   chk_enhanced_mode_select_strobe: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == ADDR_7 && !key_sel && s_q.feat_ctl[WINDOW_BIT]
      |-> enhanced_mode_wr_out)
      else $error("mode select strobe missing");
   chk_level_key_read: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && rd_in && addr_in == ADDR_0 && key_sel |=> rdata_out == $past(fifo_level_count_in))
      else $error("level count not returned");
   chk_efr_write: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == ADDR_2 && key_sel |=> enhanced_function_out == $past(wdata_in))
      else $error("enhanced function write lost");
   chk_resume_write: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == ADDR_4 && key_sel |=> s_q.resume_1 == $past(wdata_in))
      else $error("resume character write lost");
   // a frozen clock enable must hold every register, read data too
   chk_ce_freeze: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      !ce_in |=> $stable(s_q))
      else $error("state moved with enable low");

   // ----------------------------------------
   // loopback checks, then line control, id, scratch and line status checks
   // ----------------------------------------
   chk_rx_route_norm: assert property (
      @(posedge mclk_in) disable iff (rst_in) !loop |-> rx_shift_out == rx_pin_in)
      else $error("rx pin not routed outside loopback");
   chk_loop_tx_mark: assert property (
      @(posedge mclk_in) disable iff (rst_in) loop |-> tx_pin_out)
      else $error("tx pin not mark in loopback");
   chk_loop_route: assert property (
      @(posedge mclk_in) disable iff (rst_in) loop |-> rx_shift_out == tx_shift_in)
      else $error("loopback route broken");
   chk_loop_modem_out: assert property (
      @(posedge mclk_in) disable iff (rst_in) loop |-> rts_n_out && dtr_n_out)
      else $error("modem outputs active in loopback");
   chk_loop_enter: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == ADDR_4 && !key_sel |=> loop == $past(wdata_in[4]))
      else $error("loopback bit not followed");
   chk_loop_inputs: assert property (
      @(posedge mclk_in) disable iff (rst_in) loop |-> modem_lines_out == 4'h0)
      else $error("modem inputs seen in loopback");
   chk_lcr_write: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == ADDR_3 |=> line_control_out == $past(wdata_in))
      else $error("line control write lost");
   chk_id_read: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && rd_in && addr_in == ADDR_1 && id_sel |=> rdata_out == IDENT_CODE)
      else $error("id code not returned");
   chk_spr_readback: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && rd_in && addr_in == ADDR_7 && !key_sel && !s_q.feat_ctl[WINDOW_BIT]
      |=> rdata_out == $past(s_q.scratch))
      else $error("scratch pad readback wrong");
   chk_lsr_readonly: assert property (
      @(posedge mclk_in) disable iff (rst_in)
      ce_in && wr_in && addr_in == ADDR_5 && !key_sel |=> $stable(s_q[$bits(state_t)-1:8]))
      else $error("line status write changed state");
endmodule
`default_nettype wire

// ### hw/uart_regmap_pkg.sv
// constants for the uart register map and loopback block
//
// Overview of operation
// - modem_control bit 4 enables loopback
// - loopback routes tx shift output to rx
// - tx pin held high in loopback
// - rts and dtr deasserted in loopback
// - modem inputs ignored during loopback
// - all other functions run unchanged
// - top bit selects divisor bytes at 0,1
// - zero divisor exposes revision and id codes
// - address 2 fraction needs enhanced enable
// - address 0 rx holding read, tx write
// - address 1 interrupt enable when top clear
// - address 2 interrupt status and fifo control
// - address 3 always line control
// - address 4 modem control unless 0xBF
// - address 5 line status read only
// - address 6 modem status, gated write control
// - address 7 scratch pad when window clear
// - address 7 level count, mode select write
// - 0xBF: address 0 level count, trigger
// - 0xBF: feature control, enhanced function
// - 0xBF: addresses 4-7 flow characters
// - modem_control bit 6 enables infrared
package uart_regmap_pkg;
   localparam logic [2:0] ADDR_0 = 3'h0;
   localparam logic [2:0] ADDR_1 = 3'h1;
   localparam logic [2:0] ADDR_2 = 3'h2;
   localparam logic [2:0] ADDR_3 = 3'h3;
   localparam logic [2:0] ADDR_4 = 3'h4;
   localparam logic [2:0] ADDR_5 = 3'h5;
   localparam logic [2:0] ADDR_6 = 3'h6;
   localparam logic [2:0] ADDR_7 = 3'h7;
   localparam logic [7:0] ENHANCED_KEY = 8'hBF;
   localparam int LOOPBACK_BIT  = 4;
   localparam int INFRARED_BIT  = 6;
   localparam int RTS_BIT       = 1;
   localparam int DTR_BIT       = 0;
   localparam int BANK_BIT      = 7;
   localparam int ENH_EN_BIT    = 4;
   localparam int WINDOW_BIT    = 6;
   localparam int FAST_IR_BIT   = 7;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] LINE_CTL_RESET = 8'h03;
endpackage

// ### sim/line_model.sv
// far-end serial line model for the loopback checks
`timescale 1ns/1ns
`default_nettype none
module line_model (
   input  wire logic mclk_in,
   input  wire logic loop_in,
   output logic      rx_pin_out
);
   logic toggle_q = 1'b0;
   // toggles so a leaked rx pin shows up
   always @(posedge mclk_in)
   begin
      toggle_q <= ~toggle_q;
   end
   assign rx_pin_out = loop_in | toggle_q;
endmodule
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench: bank select, registers, loopback
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, a) begin total_checks++; if ((a) !== (e)) begin n_errors++; \
   $display("MISMATCH %s expected %h seen %h", nm, e, a); end end
module testbench;
   import uart_regmap_pkg::*;
   localparam logic [7:0] REV = 8'h3C;  // arbitrary
   localparam logic [7:0] IDV = 8'hC3;  // arbitrary
   logic       mclk_in = 1'b0;
   logic       rst_in = 1'b1;
   logic       wr_in = 1'b0;
   logic       ce = 1'b1;
   logic       rd_in = 1'b0;
   logic       tx_shift_in = 1'b1;
   logic       lb = 1'b0;
   logic [2:0] addr_in = 3'h0;
   logic [3:0] modem_delta_in = 4'h0;
   logic [3:0] pins = 4'hF;
   logic [7:0] wdata_in = 8'h00;
   logic [7:0] rxh = 8'h00, ists = 8'h00, lsts = 8'h00, flc = 8'h00, seed = 8'h15, m;
   logic [7:0] fcs [4];
   logic       rx_pin_in, rx_shift_out, tx_pin_out, rts_n_out, dtr_n_out, loopback_out;
   logic       infrared_en_out, infrared_fast_out, tx_holding_wr_out;
   logic [3:0] modem_lines_out;
   logic [7:0] rdata_out, divisor_frac_out, line_control_out;
   int         n_errors = 0, total_checks = 0, cycles = 0;

   uart_regmap #(.REVISION_CODE(REV), .IDENT_CODE(IDV)) DUT (
      .mclk_in, .rst_in, .ce_in(ce), .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
      .rx_holding_in(rxh), .interrupt_status_in(ists), .line_status_in(lsts),
      .fifo_level_count_in(flc), .modem_delta_in, .tx_holding_wr_out,
      .fifo_control_wr_out(), .rx_holding_rd_out(), .line_status_rd_out(),
      .modem_status_rd_out(), .fifo_trigger_wr_out(), .enhanced_mode_wr_out(),
      .wr_data_out(), .tx_shift_in, .rx_pin_in, .rx_shift_out, .tx_pin_out,
      .cts_n_in(pins[0]), .dsr_n_in(pins[1]), .ri_n_in(pins[2]), .cd_n_in(pins[3]),
      .rts_n_out, .dtr_n_out, .modem_lines_out, .loopback_out, .infrared_en_out,
      .infrared_fast_out, .divisor_low_out(), .divisor_high_out(), .divisor_frac_out,
      .interrupt_enable_out(), .line_control_out, .feature_control_out(),
      .enhanced_function_out());
   line_model far_end (.mclk_in, .loop_in(lb | loopback_out), .rx_pin_out(rx_pin_in));

   always #10 mclk_in = ~mclk_in;
   // run takes under a hundred cycles, so this only cuts hangs
   always @(posedge mclk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         n_errors++;
         conclude();
      end
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [3:0] lines_exp(input logic l, input logic [3:0] p);
      return l ? 4'h0 : ~p;
   endfunction
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      addr_in = a;
      wdata_in = d;
      rd_in = 1'b0;
      wr_in = 1'b1;
      @(posedge mclk_in);
      #2;
   endtask
   task automatic idle;
      wr_in = 1'b0;
      rd_in = 1'b0;
      @(posedge mclk_in);
      #2;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e, input string nm);
      addr_in = a;
      wr_in = 1'b0;
      rd_in = 1'b1;
      @(posedge mclk_in);
      #2;
      `CHK(nm, e, rdata_out)
   endtask
   task automatic stir;
      rxh = lfsr(seed);
      ists = lfsr(rxh);
      lsts = lfsr(ists);
      flc = lfsr(lsts);
      seed = flc;
      tx_shift_in = seed[0];
      pins = seed[4:1];
      modem_delta_in = rxh[3:0];
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ----------------------------------------
   // sequence
   // ----------------------------------------
   initial
   begin
      repeat (12) @(posedge mclk_in);
      #2 rst_in = 1'b0;
      @(posedge mclk_in);
      #2;
      stir();
      rd(ADDR_3, LINE_CTL_RESET, "line_ctl");
      wr(ADDR_3, 8'h83);
      wr(ADDR_0, rxh);
      wr(ADDR_1, ists);
      rd(ADDR_0, rxh, "div_lo");
      rd(ADDR_1, ists, "div_hi");
      wr(ADDR_2, lsts);
      `CHK("frac_off", 8'h00, divisor_frac_out)
      wr(ADDR_0, 8'h00);
      wr(ADDR_1, 8'h00);
      rd(ADDR_0, REV, "rev");
      rd(ADDR_1, IDV, "ident");
      $display("done: divisor bank");
      wr(ADDR_3, ENHANCED_KEY);
      wr(ADDR_2, 8'h10);
      rd(ADDR_2, 8'h10, "enh_fn");
      wr(ADDR_1, 8'h40);
      rd(ADDR_1, 8'h40, "feat_ctl");
      rd(ADDR_0, flc, "level_key");
      for (int i = 0; i < 4; i++)
      begin
         fcs[i] = lfsr(seed ^ 8'(i));
         wr(ADDR_4 + 3'(i), fcs[i]);
      end
      for (int i = 0; i < 4; i++)
         rd(ADDR_4 + 3'(i), fcs[i], "flowchr");
      `CHK("fast_bf", 1'b0, infrared_fast_out)
      wr(ADDR_3, 8'h80);
      wr(ADDR_2, rxh);
      `CHK("frac_on", rxh, divisor_frac_out)
      rd(ADDR_2, rxh, "frac_rd");
      $display("done: enhanced bank");
      wr(ADDR_3, 8'h03);
      stir();
      rd(ADDR_0, rxh, "rx_hold");
      wr(ADDR_0, lsts);
      `CHK("tx_hold_wr", 1'b1, tx_holding_wr_out)
      wr(ADDR_1, ~ists);
      rd(ADDR_1, ~ists, "int_en");
      rd(ADDR_2, ists, "int_stat");
      wr(ADDR_5, ~lsts);
      rd(ADDR_5, lsts, "line_stat");
      rd(ADDR_7, flc, "level_win");
      wr(ADDR_4, 8'h40);
      wr(ADDR_6, 8'h80);
      `CHK("fast_ir", 1'b1, infrared_fast_out)
      wr(ADDR_3, ENHANCED_KEY);
      wr(ADDR_1, 8'h00);
      wr(ADDR_3, 8'h03);
      wr(ADDR_7, rxh);
      rd(ADDR_7, rxh, "scratch");
      ce = 1'b0;
      wr(ADDR_3, 8'h55);
      idle();
      ce = 1'b1;
      `CHK("ce_hold", 8'h03, line_control_out)
      $display("done: normal bank");
      for (int k = 0; k < 8; k++)
      begin
         stir();
         lb = k[0];
         m = {1'b0, lb, 1'b0, lb, 4'h3};
         wr(ADDR_4, m);
         rd(ADDR_4, m, "modem_ctl");
         rd(ADDR_5, lsts, "line_stat_lb");
         `CHK("loop", lb, loopback_out)
         `CHK("txpin", lb | tx_shift_in, tx_pin_out)
         `CHK("rxsh", lb ? tx_shift_in : rx_pin_in, rx_shift_out)
         `CHK("rts", lb, rts_n_out)
         `CHK("dtr", lb, dtr_n_out)
         `CHK("lines", lines_exp(lb, pins), modem_lines_out)
         `CHK("ir", lb, infrared_en_out)
      end
      $display("done: loopback");
      conclude();
   end
endmodule
`default_nettype wire
